// *** branch_stack_map.vh ***
`ifndef BRANCH_STACK_MAP_VH
`define BRANCH_STACK_MAP_VH
// ********************************************
// register offsets
// ********************************************
`define OFS_START 4'h0
`define OFS_OPER 4'h1
`define OFS_ADDR 4'h2
`define OFS_STATUS 4'h3
`define OFS_PC 4'h4
`define OFS_SP 4'h5
`define OFS_AX 4'h6
`define OFS_BC 4'h7
`define OFS_DE 4'h8
`define OFS_HL 4'h9
`define OFS_PSW 4'ha
// ********************************************
// field positions
// ********************************************
`define OPER_OFF_LSB 0
`define OPER_BIT_LSB 8
`define OPER_SEL_LSB 11
`define PSW_CARRY 0
`define PSW_HALF 4
`define PSW_NIL 6
`define PSW_GATE 7
// ********************************************
// reset values
// ********************************************
`define RST_PC 16'h0000
`define RST_SP 16'hfee0
`define RST_PSW 8'h02
// ********************************************
// operation codes
// ********************************************
`define OP_POP 4'h0
`define OP_BR_REL 4'h1
`define OP_BR_AX 4'h2
`define OP_BC 4'h3
`define OP_BNC 4'h4
`define OP_BZ 4'h5
`define OP_BNZ 4'h6
`define OP_BT_SADDR 4'h7
`define OP_BT_SFR 4'h8
`define OP_BT_PTR 4'h9
`define OP_BF_SADDR 4'ha
`define OP_TCB_SADDR 4'hb
`define OP_TCB_PSW 4'hc
`define OP_DECREMENT_LOOP_BRANCH 4'hd
`define OP_EI 4'he
`define OP_DI 4'hf
// ********************************************
// clock counts: fast = high-speed ram or no data access
// ********************************************
`define CLK_POP 4'd4
`define CLK_REL 4'd6
`define CLK_BR_AX 4'd8
`define CLK_BT_SADDR_FAST 4'd8
`define CLK_BT_SADDR_SLOW 4'd9
`define CLK_BT_SFR 4'd11
`define CLK_BT_PTR_FAST 4'd10
`define CLK_BT_PTR_SLOW 4'd11
`define CLK_BF_FAST 4'd10
`define CLK_BF_SLOW 4'd11
`define CLK_TCB_FAST 4'd10
`define CLK_TCB_SLOW 4'd12
`define CLK_TCB_PSW 4'd12
`endif

// *** op_timing.v ***
`timescale 1ns/1ps
`default_nettype none
`include "branch_stack_map.vh"
module op_timing
(
  input wire [3:0] op,
  input wire fastArea,
  output reg [3:0] clocks,
  output reg [2:0] length
);
  always @*
  begin
    clocks = `CLK_REL;
    length = 3'd2;
    case (op)
      `OP_POP:
      begin
        clocks = `CLK_POP; // RL1
        length = 3'd1;
      end
      `OP_BR_AX: clocks = `CLK_BR_AX; // RL3
      `OP_BT_SADDR:
      begin
        clocks = fastArea ? `CLK_BT_SADDR_FAST : `CLK_BT_SADDR_SLOW; // RL8 RL17 RL18
        length = 3'd3;
      end
      `OP_BT_SFR:
      begin
        clocks = `CLK_BT_SFR; // RL9
        length = 3'd4;
      end
      `OP_BT_PTR:
      begin
        clocks = fastArea ? `CLK_BT_PTR_FAST : `CLK_BT_PTR_SLOW; // RL10 RL17 RL18
        length = 3'd3;
      end
      `OP_BF_SADDR:
      begin
        clocks = fastArea ? `CLK_BF_FAST : `CLK_BF_SLOW; // RL11
        length = 3'd4;
      end
      `OP_TCB_SADDR:
      begin
        clocks = fastArea ? `CLK_TCB_FAST : `CLK_TCB_SLOW; // RL12
        length = 3'd4;
      end
      `OP_TCB_PSW:
      begin
        clocks = `CLK_TCB_PSW; // RL13
        length = 3'd4;
      end
      default:
      begin
        clocks = `CLK_REL; // RL2 RL4 RL7 RL14 RL15 RL16
        length = 3'd2;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** rel_target.v ***
`timescale 1ns/1ps
`default_nettype none
module rel_target
(
  input wire [15:0] pc,
  input wire [2:0] length,
  input wire [7:0] offset,
  output wire [15:0] nextSeq,
  output wire [15:0] target
);
  // backward reach comes from sign extension of the offset
  assign nextSeq = pc + {13'h0000, length};
  assign target = nextSeq + {{8{offset[7]}}, offset}; // RL19
endmodule
`default_nettype wire

// *** branch_stack_ctrl_exec.v ***
// How it works
// RL1 - pop loads pair from stack, SP plus two
// RL2 - relative jump goes next address plus offset
// RL3 - indirect jump loads PC from accumulator pair
// RL4 - carry taken jump branches when carry set
// RL5 - carry free jump branches when carry clear
// RL6 - nil taken jump branches when nil set
// RL7 - nil free jump branches when nil clear
// RL8 - bit set branch, short direct, 8/9 clocks
// RL9 - bit set branch, special function, 11 clocks
// RL10 - bit set branch via pointer, 10/11 clocks
// RL11 - bit clear branch, short direct, four bytes
// RL12 - test and clear branch clears taken bit
// RL13 - test and clear on status word alters flags
// RL14 - decrement counter, branch if not zero
// RL15 - unmask sets the interrupt gate bit
// RL16 - mask clears the interrupt gate bit
// RL17 - fast count for high-speed RAM or none
// RL18 - slow count for any other area
// RL19 - offset is sign-extended two's complement
// RL20 - other branches leave flags untouched
`timescale 1ns/1ps
`default_nettype none
`include "branch_stack_map.vh"
module branch_stack_ctrl_exec
#(
  parameter [15:0] FAST_LO = 16'hfe20,
  parameter [15:0] FAST_HI = 16'hfeff
)
(
  input wire clk,
  input wire sys_rst,
  input wire [3:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdata,
  output reg [15:0] memAddr,
  output reg memRd,
  input wire [7:0] memRdata,
  output reg memWr,
  output reg [7:0] memWdata,
  output wire busy,
  output wire interruptGate
);
  // ********************************************
  // state
  // ********************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  reg [1:0] state;
  reg [3:0] cnt;
  reg [3:0] op;
  reg [15:0] oper;
  reg [15:0] operAddr;
  reg [15:0] pc;
  reg [15:0] sp;
  reg [15:0] ax;
  reg [15:0] bc;
  reg [15:0] de;
  reg [15:0] hl;
  reg [7:0] program_status_word;
  reg [7:0] data0;
  reg [7:0] data1;
  reg lastTaken;
  reg [3:0] lastClocks;

  // ********************************************
  // helpers
  // ********************************************
  function inFast;
    input [15:0] a;
    begin
      inFast = (a >= FAST_LO) && (a <= FAST_HI);
    end
  endfunction

  function [7:0] clearBit;
    input [7:0] v;
    input [2:0] n;
    begin
      clearBit = v & ~(8'h01 << n);
    end
  endfunction

  wire [7:0] offset = oper[`OPER_OFF_LSB +: 8];
  wire [2:0] bitNum = oper[`OPER_BIT_LSB +: 3];
  wire [1:0] pairSel = oper[`OPER_SEL_LSB +: 2];
  wire startReq = regWr && (regAddr == `OFS_START) && (state == ST_IDLE);
  wire [3:0] newOp = regWdata[3:0];

  // data address of the operand; the pointer form goes through the pair register
  wire [15:0] dataAddr = (newOp == `OP_BT_PTR) ? hl : operAddr;
  wire fastNow = inFast(dataAddr);

  wire [3:0] startClocks;
  wire [2:0] startLen;
  reg fastLatched;
  wire [3:0] runClocks;
  wire [2:0] runLen;

  op_timing u_start_timing
  (
    .op(newOp),
    .fastArea(fastNow),
    .clocks(startClocks),
    .length(startLen)
  );

  op_timing u_run_timing
  (
    .op(op),
    .fastArea(fastLatched),
    .clocks(runClocks),
    .length(runLen)
  );

  wire [15:0] nextSeq;
  wire [15:0] target;

  rel_target u_target
  (
    .pc(pc),
    .length(runLen),
    .offset(offset),
    .nextSeq(nextSeq),
    .target(target)
  );

  // ********************************************
  // branch decision
  // ********************************************
  wire memBit = data0[bitNum];
  wire pswBit = program_status_word[bitNum];
  wire [7:0] decB = bc[15:8] - 8'h01;
  wire [7:0] decC = bc[7:0] - 8'h01;
  wire [7:0] decVal = pairSel[0] ? decC : decB;
  reg taken;

  always @*
  begin
    taken = 1'b0;
    case (op)
      `OP_BR_REL: taken = 1'b1; // RL2
      `OP_BC: taken = program_status_word[`PSW_CARRY]; // RL4
      `OP_BNC: taken = ~program_status_word[`PSW_CARRY]; // RL5
      `OP_BZ: taken = program_status_word[`PSW_NIL]; // RL6
      `OP_BNZ: taken = ~program_status_word[`PSW_NIL]; // RL7
      `OP_BT_SADDR: taken = memBit; // RL8
      `OP_BT_SFR: taken = memBit; // RL9
      `OP_BT_PTR: taken = memBit; // RL10
      `OP_BF_SADDR: taken = ~memBit; // RL11
      `OP_TCB_SADDR: taken = memBit; // RL12
      `OP_TCB_PSW: taken = pswBit; // RL13
      `OP_DECREMENT_LOOP_BRANCH: taken = (decVal != 8'h00); // RL14
      default: taken = 1'b0;
    endcase
  end

  wire lastCycle = (state == ST_EXEC) && (cnt == runClocks);
  assign busy = (state == ST_EXEC);
  assign interruptGate = program_status_word[`PSW_GATE];

  // ********************************************
  // sequencer and memory port
  // ********************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      op <= `OP_BR_REL;
      fastLatched <= 1'b1;
      memAddr <= 16'h0000;
      memRd <= 1'b0;
      memWr <= 1'b0;
      memWdata <= 8'h00;
      data0 <= 8'h00;
      data1 <= 8'h00;
      lastTaken <= 1'b0;
      lastClocks <= 4'h0;
    end
    else
    begin
      memRd <= 1'b0;
      memWr <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (startReq)
          begin
            state <= ST_EXEC;
            op <= newOp;
            cnt <= 4'h1;
            fastLatched <= fastNow; // RL17 RL18
            lastClocks <= startClocks;
            case (newOp)
              `OP_POP:
              begin
                memRd <= 1'b1;
                memAddr <= sp; // RL1
              end
              `OP_BT_SADDR, `OP_BT_SFR, `OP_BT_PTR, `OP_BF_SADDR, `OP_TCB_SADDR:
              begin
                memRd <= 1'b1;
                memAddr <= dataAddr;
              end
              default: memRd <= 1'b0;
            endcase
          end
        end
        ST_EXEC:
        begin
          cnt <= cnt + 4'h1;
          if ((cnt == 4'h1) && (op == `OP_POP))
          begin
            memRd <= 1'b1;
            memAddr <= sp + 16'h0001; // RL1
          end
          if (cnt == 4'h2)
            data0 <= memRdata;
          if (cnt == 4'h3)
            data1 <= memRdata;
          if (lastCycle)
          begin
            state <= ST_IDLE;
            lastTaken <= taken;
            // the cleared byte goes back only when the branch is taken
            if ((op == `OP_TCB_SADDR) && taken)
            begin
              memWr <= 1'b1; // RL12
              memWdata <= clearBit(data0, bitNum);
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ********************************************
  // architectural registers
  // ********************************************
  // software writes are ignored while an operation runs, so commit never races them
  wire swWr = regWr && (state == ST_IDLE);

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pc <= `RST_PC;
      sp <= `RST_SP;
      ax <= 16'h0000;
      bc <= 16'h0000;
      de <= 16'h0000;
      hl <= 16'h0000;
      program_status_word <= `RST_PSW;
      oper <= 16'h0000;
      operAddr <= 16'h0000;
    end
    else if (lastCycle)
    begin
      if (op == `OP_BR_AX)
        pc <= ax; // RL3
      else if (taken)
        pc <= target; // RL2
      else
        pc <= nextSeq; // RL20
      case (op)
        `OP_POP:
        begin
          case (pairSel)
            // the high byte is held in data1; the read port only answers in the cycle after the strobe
            2'd0: ax <= {data1, data0}; // RL1
            2'd1: bc <= {data1, data0};
            2'd2: de <= {data1, data0};
            default: hl <= {data1, data0};
          endcase
          sp <= sp + 16'h0002; // RL1
        end
        `OP_DECREMENT_LOOP_BRANCH:
        begin
          if (pairSel[0])
            bc[7:0] <= decC; // RL14
          else
            bc[15:8] <= decB; // RL14
        end
        `OP_TCB_PSW:
        begin
          if (taken)
            program_status_word <= clearBit(program_status_word, bitNum); // RL13
        end
        `OP_EI: program_status_word[`PSW_GATE] <= 1'b1; // RL15
        `OP_DI: program_status_word[`PSW_GATE] <= 1'b0; // RL16
        default: program_status_word <= program_status_word; // RL20
      endcase
    end
    else if (swWr)
    begin
      case (regAddr)
        `OFS_OPER: oper <= regWdata;
        `OFS_ADDR: operAddr <= regWdata;
        `OFS_PC: pc <= regWdata;
        `OFS_SP: sp <= regWdata;
        `OFS_AX: ax <= regWdata;
        `OFS_BC: bc <= regWdata;
        `OFS_DE: de <= regWdata;
        `OFS_HL: hl <= regWdata;
        `OFS_PSW: program_status_word <= regWdata[7:0];
        default: oper <= oper;
      endcase
    end
  end

  // ********************************************
  // register read port
  // ********************************************
  always @(posedge clk)
  begin
    if (sys_rst)
      regRdata <= 16'h0000;
    else if (regRd)
    begin
      case (regAddr)
        `OFS_OPER: regRdata <= oper;
        `OFS_ADDR: regRdata <= operAddr;
        `OFS_STATUS: regRdata <= {8'h00, lastClocks, 2'b00, lastTaken, busy};
        `OFS_PC: regRdata <= pc;
        `OFS_SP: regRdata <= sp;
        `OFS_AX: regRdata <= ax;
        `OFS_BC: regRdata <= bc;
        `OFS_DE: regRdata <= de;
        `OFS_HL: regRdata <= hl;
        `OFS_PSW: regRdata <= {8'h00, program_status_word};
        default: regRdata <= 16'h0000;
      endcase
    end
    else
      regRdata <= 16'h0000;
  end

endmodule
`default_nettype wire

// *** data_space_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module data_space_model
(
  input wire logic clk,
  input wire logic [15:0] memAddr,
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  // ****
  // byte store with one-cycle read answer
  // ****
  logic [7:0] mem [0:65535];
  initial memRdata = 8'h00;
  // stale data flips every cycle without a read, so a sample one cycle late sees the inverted byte
  always @(posedge clk)
  begin
    if (memRd)
      memRdata <= mem[memAddr];
    else
      memRdata <= ~memRdata;
    if (memWr)
      mem[memAddr] <= memWdata;
  end
endmodule
`default_nettype wire

// *** branch_stack_ctrl_exec_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module branch_stack_ctrl_exec_assertions
#(
  parameter [15:0] FAST_LO = 16'hfe20,
  parameter [15:0] FAST_HI = 16'hfeff
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic [15:0] memAddr,
  input wire logic memRd,
  input wire logic busy,
  input wire logic interruptGate
);
  // ****
  // operation timing and interrupt gate result
  // ****
  logic go;
  logic fast;
  logic [3:0] op;
  assign go = regWr && regAddr == 4'h0 && !busy;
  assign op = regWdata[3:0];
  assign fast = memAddr >= FAST_LO && memAddr <= FAST_HI;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  pop_timing_a: assert property (go && op == 4'h0 |=> busy && memRd ##1 memRd &&
    memAddr == $past(memAddr) + 16'h0001 ##0 busy[*3] ##1 !busy) else $error("pop timing wrong");
  rel_timing_a: assert property (go && (op == 4'h1 || (op >= 4'h3 && op <= 4'h6) || op >= 4'hd)
    |=> busy[*6] ##1 !busy) else $error("six clock op wrong");
  ax_timing_a: assert property (go && op == 4'h2 |=> busy[*8] ##1 !busy)
    else $error("indirect jump timing wrong");
  sfr_timing_a: assert property (go && op == 4'h8 |=> busy[*8] ##1 busy[*3] ##1 !busy)
    else $error("sfr bit test timing wrong");
  bt_fast_a: assert property (go && op == 4'h7 ##1 fast |-> busy[*8] ##1 !busy)
    else $error("fast bit test timing wrong");
  bt_slow_a: assert property (go && op == 4'h7 ##1 !fast |-> busy[*8] ##1 busy ##1 !busy)
    else $error("slow bit test timing wrong");
  tcb_slow_a: assert property (go && op == 4'hb ##1 !fast |-> busy[*8] ##1 busy[*4] ##1 !busy)
    else $error("slow test clear timing wrong");
  gate_write_a: assert property (go && op[3:1] == 3'h7 |-> ##7 interruptGate == !$past(regWdata[0], 7))
    else $error("gate bit not written");
endmodule
bind branch_stack_ctrl_exec branch_stack_ctrl_exec_assertions #(.FAST_LO(FAST_LO), .FAST_HI(FAST_HI)) u_chk
  (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .memAddr(memAddr), .memRd(memRd), .busy(busy), .interruptGate(interruptGate));
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****
  // bench
  // ****
  typedef struct packed {logic [3:0] op; logic [7:0] program_status_word; logic [15:0] oper;
    logic [15:0] pc; logic [3:0] clks; logic [7:0] epsw;} row_t;
  logic clk, sys_rst, regWr, regRd, memRd, memWr, busy, interruptGate;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, memAddr, d;
  logic [7:0] memRdata, memWdata;
  int mismatches, compares, i, n;
  row_t rows [15] = '{
    '{4'h1, 8'h02, 16'h0010, 16'h1012, 4'h6, 8'h02}, '{4'h1, 8'h02, 16'h00f0, 16'h0ff2, 4'h6, 8'h02},
    '{4'h3, 8'h03, 16'h0010, 16'h1012, 4'h6, 8'h03}, '{4'h3, 8'h02, 16'h0010, 16'h1002, 4'h6, 8'h02},
    '{4'h4, 8'h02, 16'h0010, 16'h1012, 4'h6, 8'h02}, '{4'h4, 8'h03, 16'h0010, 16'h1002, 4'h6, 8'h03},
    '{4'h5, 8'h42, 16'h0010, 16'h1012, 4'h6, 8'h42}, '{4'h5, 8'h02, 16'h0010, 16'h1002, 4'h6, 8'h02},
    '{4'h6, 8'h02, 16'h0010, 16'h1012, 4'h6, 8'h02}, '{4'h6, 8'h42, 16'h0010, 16'h1002, 4'h6, 8'h42},
    '{4'h2, 8'h02, 16'h0000, 16'h1234, 4'h8, 8'h02}, '{4'hd, 8'h02, 16'h0010, 16'h1012, 4'h6, 8'h02},
    '{4'hd, 8'h02, 16'h0810, 16'h1002, 4'h6, 8'h02}, '{4'he, 8'h02, 16'h0000, 16'h1002, 4'h6, 8'h82},
    '{4'hf, 8'h82, 16'h0000, 16'h1002, 4'h6, 8'h02}};
  branch_stack_ctrl_exec u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .memAddr(memAddr), .memRd(memRd), .memRdata(memRdata),
    .memWr(memWr), .memWdata(memWdata), .busy(busy), .interruptGate(interruptGate));
  data_space_model u_mem (.clk(clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWdata(memWdata),
    .memRdata(memRdata));
  task complete_run;
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1;
    d = regRdata;
  endtask
  // pc always starts at 1000 so every target is worked out from one base
  task go(input logic [3:0] op, input logic [7:0] program_status_word, input logic [15:0] oper, input logic [15:0] adr,
    input logic [3:0] en, input logic [15:0] epc, input logic [7:0] epsw);
    wr(4'h4, 16'h1000);
    wr(4'ha, {8'h00, program_status_word});
    wr(4'h1, oper);
    wr(4'h2, adr);
    wr(4'h0, {12'h000, op});
    n = 0;
    #1;
    while (busy === 1'h1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40)
    begin
      mismatches++;
      complete_run;
    end
    chk("clocks", {12'h000, en}, n[15:0]);
    rd(4'h4);
    chk("pc", epc, d);
    rd(4'ha);
    chk("psw", {8'h00, epsw}, d);
    chk("gate", {15'h0000, epsw[7]}, {15'h0000, interruptGate});
  endtask
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    sys_rst = 1'h1;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    regWr = 1'h0;
    regRd = 1'h0;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    rd(4'h5);
    chk("sp reset", 16'hfee0, d);
    rd(4'hf);
    chk("unmapped", 16'h0000, d);
    wr(4'h6, 16'h1234);
    wr(4'h7, 16'h0201);
    for (i = 0; i < 15; i++)
      go(rows[i].op, rows[i].program_status_word, rows[i].oper, 16'h0000, rows[i].clks, rows[i].pc, rows[i].epsw);
    u_mem.mem[16'hfe40] = 8'h34;
    u_mem.mem[16'hfe41] = 8'h12;
    wr(4'h5, 16'hfe40);
    go(4'h0, 8'h02, 16'h0800, 16'h0000, 4'h4, 16'h1001, 8'h02);
    rd(4'h7);
    chk("pair", 16'h1234, d);
    rd(4'h5);
    chk("sp", 16'hfe42, d);
    u_mem.mem[16'hfe30] = 8'h08;
    go(4'h7, 8'h02, 16'h0310, 16'hfe30, 4'h8, 16'h1013, 8'h02);
    u_mem.mem[16'h8000] = 8'hf7;
    go(4'h7, 8'h02, 16'h0310, 16'h8000, 4'h9, 16'h1003, 8'h02);
    go(4'ha, 8'h02, 16'h0210, 16'hfe30, 4'ha, 16'h1014, 8'h02);
    u_mem.mem[16'hff20] = 8'h01;
    go(4'h8, 8'h02, 16'h0010, 16'hff20, 4'hb, 16'h1014, 8'h02);
    wr(4'h9, 16'hfe30);
    go(4'h9, 8'h02, 16'h03f0, 16'h0000, 4'ha, 16'h0ff3, 8'h02);
    u_mem.mem[16'hfe60] = 8'h81;
    go(4'hb, 8'h02, 16'h0710, 16'hfe60, 4'ha, 16'h1014, 8'h02);
    chk("cleared", 16'h0001, {8'h00, u_mem.mem[16'hfe60]});
    u_mem.mem[16'h9000] = 8'h00;
    go(4'hb, 8'h02, 16'h0010, 16'h9000, 4'hc, 16'h1004, 8'h02);
    go(4'hc, 8'hd3, 16'h0610, 16'h0000, 4'hc, 16'h1014, 8'h93);
    rd(4'h3);
    chk("status", 16'h00c2, d);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    rd(4'h4);
    chk("pc reset", 16'h0000, d);
    complete_run;
  end
endmodule
`default_nettype wire
